// file: hsc_cpu_model.sv
// Behavioural CPU core and interrupt request latch facing the controller.
// Assumes the bench raises haltReq as a level and sets irqSet as levels.
`timescale 1ns/100ps
module hsc_cpu_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Bench controls
  input  wire logic       haltReq,
  input  wire logic [7:0] irqSet,
  // Controller answers
  input  wire logic       vectorStart,
  input  wire logic       resumeStart,
  input  wire logic       resetVectorStart,
  // Controller requests
  output logic            haltExec,
  output logic [7:0]      irqRequest
);
  ////////////////////////////////////////////////////////////
  logic run;
  // The program clears its flags on wake, else a stale request would end the next halt at once.
  // No pin-clocked peripheral is ever started here.
  always_ff @(posedge clk) begin
    if (rst) begin
      run        <= 1'h1;
      haltExec   <= 1'h0;
      irqRequest <= 8'h00;
    end else begin
      haltExec   <= haltReq && run && !haltExec;
      if (haltExec) run <= 1'h0;
      if (vectorStart || resumeStart || resetVectorStart) run <= 1'h1;
      irqRequest <= (vectorStart || resumeStart || resetVectorStart) ? 8'h00 : (irqRequest | irqSet);
    end
  end
endmodule // hsc_cpu_model

// file: hsc_halt_standby.sv
// Halt standby controller: gates the CPU and flash clocks on a halt instruction,
// keeps oscillators and peripherals running except the watchdog clock when the option strap is set and the buzzer when the
// subsystem source feeds the CPU with the peripheral clock off, and releases on interrupt or reset.
// Assumes the CPU core, interrupt controller and reset block share clk.
`timescale 1ns/100ps
module hsc_halt_standby #(
  parameter int NUM_IRQ = 8
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // CPU core
  input  wire logic                       haltExec,
  input  wire hsc_pkg::hsc_cpu_flags_type cpuFlags,
  output logic                            vectorStart,
  output logic                            resumeStart,
  output logic                            resetVectorStart,
  output logic                            halted,
  // Interrupt controller
  input  wire logic [NUM_IRQ-1:0]         irqRequest,
  input  wire logic [NUM_IRQ-1:0]         requestMaskFlag,
  input  wire logic [NUM_IRQ-1:0]         rankSelectFlag,
  // Reset block and option strap
  input  wire logic                       sysResetReq,
  input  wire logic                       wdtStoppableStrap,
  // Clock gates and oscillator enables
  output hsc_pkg::hsc_gate_type           gates,
  output hsc_pkg::hsc_src_type            cpuClkSource
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  hsc_pkg::hsc_state_type state_reg;
  hsc_pkg::hsc_state_type state_next;
  hsc_pkg::hsc_cause_type cause_reg;
  hsc_pkg::hsc_cause_type cause_next;
  hsc_pkg::hsc_gate_type  gate_reg;
  hsc_pkg::hsc_gate_type  gate_next;
  logic [31:0]            ctrl_reg;
  logic [31:0]            ctrl_next;
  logic [31:0]            prdata_reg;
  logic [31:0]            prdata_next;
  logic                   pready_reg;
  logic                   pready_next;
  logic                   pslverr_reg;
  logic                   pslverr_next;
  logic                   vector_reg;
  logic                   vector_next;
  logic                   resume_reg;
  logic                   resume_next;
  logic                   resetVec_reg;
  logic                   resetVec_next;
  logic                   halted_reg;
  logic                   halted_next;
  logic                   timerLoad;
  logic [hsc_pkg::WAIT_W-1:0] timerVal;
  logic                   timerDone;
  logic                   wdtStoppable;
  logic                   wakeAny;
  logic                   serviceOk;
  logic                   apbAccess;
  logic                   apbCommit;
  logic                   addrCtrl;
  logic                   addrStatus;
  logic [31:0]            statusWord;
  hsc_pkg::hsc_src_type   srcSel;

  //////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser and release wait timer.

  hsc_sync3 u_strap_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (wdtStoppableStrap),
    .syncOut (wdtStoppable)
  );

  hsc_wait_timer #(
    .W (hsc_pkg::WAIT_W)
  ) u_wait (
    .clk     (clk),
    .rst     (rst),
    .load    (timerLoad),
    .loadVal (timerVal),
    .done    (timerDone)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Release decision from the interrupt flags.

  // A source both pending and unmasked wakes; a masked one leaves the core halted.
  // One qualifying source is enough to vector; the others only decide that the core wakes.
  // Sources are not ranked against each other here, since the interrupt controller does that.
  always_comb begin
    wakeAny   = 1'b0;
    serviceOk = 1'b0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (irqRequest[i] && !requestMaskFlag[i]) begin
        wakeAny = 1'b1;
        if (!rankSelectFlag[i]) begin
          serviceOk = serviceOk | cpuFlags.globalIrqAllowFlag;
        end else begin
          serviceOk = serviceOk | (cpuFlags.globalIrqAllowFlag & cpuFlags.inServiceLevelFlag);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Halt state machine.

  always_comb begin
    state_next    = state_reg;
    cause_next    = cause_reg;
    timerLoad     = 1'b0;
    timerVal      = hsc_pkg::RESUME_WAIT_CYC;
    vector_next   = 1'b0;
    resume_next   = 1'b0;
    resetVec_next = 1'b0;
    case (state_reg)
      hsc_pkg::ST_RUN: begin
        // Any selected source may be running when halt is taken.
        if (haltExec) begin
          state_next = hsc_pkg::ST_HALTED;
        end
      end
      hsc_pkg::ST_HALTED: begin
        if (wakeAny) begin
          timerLoad = 1'b1;
          if (serviceOk) begin
            timerVal   = hsc_pkg::SERVICE_WAIT_CYC;
            state_next = hsc_pkg::ST_WAKE_VEC;
          end else begin
            timerVal   = hsc_pkg::RESUME_WAIT_CYC;
            state_next = hsc_pkg::ST_WAKE_NEXT;
          end
        end
      end
      hsc_pkg::ST_WAKE_VEC: begin
        // A halt instruction during the wait is dropped, as the core is not yet running.
        if (timerDone) begin
          state_next  = hsc_pkg::ST_RUN;
          cause_next  = hsc_pkg::CAUSE_VECTOR;
          vector_next = 1'b1;
        end
      end
      hsc_pkg::ST_WAKE_NEXT: begin
        if (timerDone) begin
          state_next  = hsc_pkg::ST_RUN;
          cause_next  = hsc_pkg::CAUSE_NEXT;
          resume_next = 1'b1;
        end
      end
      hsc_pkg::ST_RESET: begin
        state_next    = hsc_pkg::ST_RUN;
        cause_next    = hsc_pkg::CAUSE_RESET;
        resetVec_next = 1'b1;
      end
      default: begin
        state_next = hsc_pkg::ST_RUN;
      end
    endcase
    // Reset processing overrides every other release path.
    // The wait timer is left to run down; a fresh load comes with the next release.
    if (sysResetReq) begin
      state_next    = hsc_pkg::ST_RESET;
      timerLoad     = 1'b0;
      vector_next   = 1'b0;
      resume_next   = 1'b0;
      resetVec_next = 1'b0;
    end
    halted_next = (state_next == hsc_pkg::ST_HALTED);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= hsc_pkg::ST_RUN;
      cause_reg    <= hsc_pkg::CAUSE_NONE;
      vector_reg   <= 1'b0;
      resume_reg   <= 1'b0;
      resetVec_reg <= 1'b0;
      halted_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cause_reg    <= cause_next;
      vector_reg   <= vector_next;
      resume_reg   <= resume_next;
      resetVec_reg <= resetVec_next;
      halted_reg   <= halted_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave and control register.

  assign apbAccess  = psel && penable;
  assign apbCommit  = apbAccess && pready_reg;
  assign addrCtrl   = (paddr == hsc_pkg::CTRL_OFFSET);
  assign addrStatus = (paddr == hsc_pkg::STATUS_OFFSET);
  assign srcSel     = hsc_pkg::hsc_src_type'(ctrl_reg[hsc_pkg::SRC_LSB +: 2]);

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[hsc_pkg::STATE_LSB +: 3] = state_reg;
    statusWord[hsc_pkg::HALTED_BIT]     = halted_reg;
    statusWord[hsc_pkg::CAUSE_LSB +: 2] = cause_reg;
    statusWord[hsc_pkg::WDTOPT_BIT]     = wdtStoppable;
  end

  // One wait state: pready rises in the second access cycle and the write lands there.
  always_comb begin
    pready_next  = 1'b0;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    ctrl_next    = ctrl_reg;
    // Status writes complete without error and change nothing.
    if (apbAccess && !pready_reg) begin
      pready_next  = 1'b1;
      pslverr_next = !(addrCtrl || addrStatus);
      if (!pwrite) begin
        prdata_next = addrCtrl ? ctrl_reg : (addrStatus ? statusWord : 32'h0000_0000);
      end
    end
    // The selection is held through halt so an interrupt release returns to the same source; reset processing reloads CTRL_RESET.
    if (apbCommit && pwrite && addrCtrl) begin
      ctrl_next = pwdata & hsc_pkg::CTRL_WMASK;
    end
    // Reset processing restores the control register like any device reset.
    if (sysResetReq) begin
      ctrl_next = hsc_pkg::CTRL_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg    <= hsc_pkg::CTRL_RESET;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock gates and oscillator enables.

  always_comb begin
    gate_next = '0;
    // The CPU and flash restart when the release wait ends, or at once when reset processing starts, with no stabilisation delay.
    gate_next.cpu   = (state_next == hsc_pkg::ST_RUN) || (state_next == hsc_pkg::ST_RESET);
    gate_next.flash = gate_next.cpu;
    // Software settings are kept as they were; halt never touches them.
    gate_next.crystalMain  = ctrl_next[hsc_pkg::XMAIN_BIT];
    gate_next.intHigh      = ctrl_next[hsc_pkg::INTHI_BIT];
    gate_next.slowInt      = ctrl_next[hsc_pkg::SLOW_BIT];
    gate_next.watchCrystal = ctrl_next[hsc_pkg::WATCH_BIT];
    // The source feeding the CPU is forced on regardless of its enable bit.
    case (hsc_pkg::hsc_src_type'(ctrl_next[hsc_pkg::SRC_LSB +: 2]))
      hsc_pkg::SRC_HIGH_SPEED: begin
        gate_next.crystalMain = 1'b1;
      end
      hsc_pkg::SRC_INT_HIGH: begin
        gate_next.intHigh = 1'b1;
      end
      hsc_pkg::SRC_SUBSYSTEM: begin
        gate_next.watchCrystal = 1'b1;
      end
      default: begin
        // Encoding three is unused; the internal high-speed source stands in so the CPU never starves.
        gate_next.intHigh = 1'b1;
      end
    endcase
    // The slow oscillator can only be stopped when the option strap allows it.
    if (!wdtStoppable) begin
      gate_next.slowInt = 1'b1;
    end
    // With the option set the watchdog loses its clock for the whole halt, even when the slow
    // oscillator itself runs on; outside halt it simply follows that oscillator.
    if (halted_next) begin
      gate_next.wdt = !wdtStoppable;
    end else begin
      gate_next.wdt = !wdtStoppable || gate_next.slowInt;
    end
    gate_next.periph = ctrl_next[hsc_pkg::PERIPH_BIT];
    gate_next.buzzer = ctrl_next[hsc_pkg::BUZZ_BIT];
    if (halted_next && (srcSel == hsc_pkg::SRC_SUBSYSTEM) && !ctrl_next[hsc_pkg::PERIPH_BIT]) begin
      gate_next.buzzer = 1'b0;
    end
    // External clock inputs are never gated here; the supplier alone decides.
    gate_next.extMainPass = 1'b1;
    gate_next.extSubPass  = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_reg <= '0;
    end else begin
      gate_reg <= gate_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign vectorStart      = vector_reg;
  assign resumeStart      = resume_reg;
  assign resetVectorStart = resetVec_reg;
  assign halted           = halted_reg;
  assign gates            = gate_reg;
  // The source select leaves straight from the control flops, so it needs no extra stage.
  assign cpuClkSource     = srcSel;

endmodule // hsc_halt_standby

// file: hsc_halt_standby_properties.sv
// Concurrent checks on the ports of the halt standby controller.
// Assumes a bind from the bench top file and a single clock domain.
`timescale 1ns/100ps
module hsc_halt_standby_properties #(
  parameter int NUM_IRQ = 8
) (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // CPU core
  input wire logic                       haltExec,
  input wire hsc_pkg::hsc_cpu_flags_type cpuFlags,
  input wire logic                       vectorStart,
  input wire logic                       resumeStart,
  input wire logic                       resetVectorStart,
  input wire logic                       halted,
  // Interrupt controller
  input wire logic [NUM_IRQ-1:0]         irqRequest,
  input wire logic [NUM_IRQ-1:0]         requestMaskFlag,
  input wire logic [NUM_IRQ-1:0]         rankSelectFlag,
  // Reset request, strap and clock gates
  input wire logic                       sysResetReq,
  input wire logic                       wdtStoppableStrap,
  input wire hsc_pkg::hsc_gate_type      gates,
  input wire hsc_pkg::hsc_src_type       cpuClkSource
);
  ////////////////////////////////////////////////////////////
  logic [NUM_IRQ-1:0] live;
  logic               unm;
  logic               svc;
  logic               srcOn;
  always_comb begin
    live  = irqRequest & ~requestMaskFlag;
    unm   = |live;
    svc   = cpuFlags.globalIrqAllowFlag && |(live & (~rankSelectFlag | {NUM_IRQ{cpuFlags.inServiceLevelFlag}}));
    srcOn = (cpuClkSource == hsc_pkg::SRC_SUBSYSTEM) ? gates.watchCrystal :
            (cpuClkSource == hsc_pkg::SRC_INT_HIGH) ? gates.intHigh : gates.crystalMain;
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence vecWake;
    !halted ##8 vectorStart;
  endsequence
  sequence nextWake;
    !halted ##2 resumeStart;
  endsequence
  AST_ENTER: assert property (haltExec && !halted && !sysResetReq |=> halted)
    else $error("halt instruction did not halt");
  AST_GATED: assert property (halted |-> !gates.cpu && !gates.flash)
    else $error("cpu or flash clock runs while halted");
  AST_SRC_ON: assert property (halted |-> srcOn)
    else $error("selected source stopped while halted");
  AST_HOLD: assert property (halted && !unm && !sysResetReq |=> halted && $stable(gates))
    else $error("masked halt not held steady");
  AST_VEC: assert property (halted && svc && !sysResetReq |=> vecWake)
    else $error("vectored release timing wrong");
  AST_NEXT: assert property (halted && unm && !svc && !sysResetReq |=> nextWake)
    else $error("resume release timing wrong");
  AST_RESET: assert property (halted && sysResetReq |=> ##1 resetVectorStart)
    else $error("reset did not restart at reset vector");
  AST_WDT: assert property ($stable(wdtStoppableStrap)[*8] ##0 halted |-> gates.wdt == !wdtStoppableStrap)
    else $error("watchdog clock wrong in halt");
  AST_BUZZ: assert property (halted && cpuClkSource == hsc_pkg::SRC_SUBSYSTEM && !gates.periph |-> !gates.buzzer)
    else $error("buzzer runs without peripheral clock");
  AST_EXT: assert property (halted |-> gates.extMainPass && gates.extSubPass)
    else $error("external clock input blocked in halt");
  AST_CLK_BACK: assert property (vectorStart || resumeStart |-> gates.cpu && gates.flash)
    else $error("cpu clock not restored on release");
endmodule // hsc_halt_standby_properties

// file: hsc_halt_standby_tb.sv
// Self-checking bench for the halt standby controller.
// Assumes hsc_pkg, the design and hsc_cpu_model are compiled first.
`timescale 1ns/100ps
module hsc_halt_standby_tb;
  localparam logic [5:0] ROWS [6] = '{6'h02, 6'h09, 6'h16, 6'h1a, 6'h1d, 6'h20};
  logic                       clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic                       haltReq, haltExec, vectorStart, resumeStart, resetVectorStart, halted;
  logic                       sysResetReq, wdtStoppableStrap, per;
  logic [7:0]                 paddr, irqSet, irqRequest, requestMaskFlag, rankSelectFlag;
  logic [31:0]                pwdata, prdata, rd, ctrl;
  logic [5:0]                 r;
  logic [1:0]                 s;
  hsc_pkg::hsc_cpu_flags_type cpuFlags;
  hsc_pkg::hsc_gate_type      gates;
  hsc_pkg::hsc_src_type       cpuClkSource;
  int                         error_cnt, checks;
  ////////////////////////////////////////////////////////////
  hsc_halt_standby hsc_halt_standby_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .haltExec(haltExec), .cpuFlags(cpuFlags), .vectorStart(vectorStart),
    .resumeStart(resumeStart), .resetVectorStart(resetVectorStart), .halted(halted),
    .irqRequest(irqRequest), .requestMaskFlag(requestMaskFlag), .rankSelectFlag(rankSelectFlag),
    .sysResetReq(sysResetReq), .wdtStoppableStrap(wdtStoppableStrap), .gates(gates),
    .cpuClkSource(cpuClkSource));
  hsc_cpu_model hsc_cpu_model_i (.clk(clk), .rst(rst), .haltReq(haltReq), .irqSet(irqSet),
    .vectorStart(vectorStart), .resumeStart(resumeStart), .resetVectorStart(resetVectorStart),
    .haltExec(haltExec), .irqRequest(irqRequest));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1);
    chk(n, 2);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic halt_now;
    haltReq <= 1'h1;
    for (int k = 0; k < 20 && halted !== 1'h1; k++) @(posedge clk);
    haltReq <= 1'h0;
    chk(halted, 1);
  endtask
  task automatic finish_test;
    $display("Counts: %0d mismatches in %0d checks", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    {rst, psel, penable, pwrite, haltReq, sysResetReq, wdtStoppableStrap} = 7'h40;
    {paddr, pwdata, irqSet, requestMaskFlag, rankSelectFlag} = 64'h0;
    cpuFlags = 2'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, hsc_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, hsc_pkg::CTRL_RESET);
    apb(1'h1, hsc_pkg::CTRL_OFFSET, 32'hffff_fff2);
    apb(1'h0, hsc_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, 32'hffff_fff2 & hsc_pkg::CTRL_WMASK);
    apb(1'h0, 8'h08, 32'h0);
    chk(err, 1);
    chk(rd, 32'h0);
    // Each row walks one line of the flag table on a rotating CPU clock source.
    for (int i = 0; i < 6; i++) begin
      r = ROWS[i];
      s = 2'(i % 3);
      per = (i < 3);
      wdtStoppableStrap <= i[1];
      requestMaskFlag   <= {8{r[5]}};
      rankSelectFlag    <= {8{r[4]}};
      cpuFlags          <= hsc_pkg::hsc_cpu_flags_type'(r[3:2]);
      ctrl = {22'h0, per, 1'h1, i[0], 3'h7, 2'h0, s};
      apb(1'h1, hsc_pkg::CTRL_OFFSET, ctrl);
      halt_now();
      repeat (4) @(posedge clk);
      chk({gates.cpu, gates.flash}, 0);
      chk(gates.wdt, !i[1]);
      chk(gates.periph, per);
      chk(gates.watchCrystal, i[0] | (s == 2'h2));
      if (s == 2'h2) chk(gates.buzzer, per);
      irqSet <= 8'h01 << i;
      if (r[1:0] == 2'h0) begin
        repeat (20) @(posedge clk);
        chk(halted, 1);
        requestMaskFlag <= 8'h00;
      end
      for (int k = 0; k < 40 && !(vectorStart || resumeStart); k++) @(posedge clk);
      chk({vectorStart, resumeStart}, (r[1:0] == 2'h1) ? 2'h2 : 2'h1);
      irqSet <= 8'h00;
      apb(1'h0, hsc_pkg::STATUS_OFFSET, 32'h0);
      chk(rd[5:4], (r[1:0] == 2'h1) ? 2'h1 : 2'h2);
    end
    apb(1'h1, hsc_pkg::CTRL_OFFSET, 32'h0000_03f2);
    halt_now();
    sysResetReq <= 1'h1;
    @(posedge clk);
    sysResetReq <= 1'h0;
    for (int k = 0; k < 20 && resetVectorStart !== 1'h1; k++) @(posedge clk);
    chk(resetVectorStart, 1);
    apb(1'h0, hsc_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, hsc_pkg::CTRL_RESET);
    apb(1'h0, hsc_pkg::STATUS_OFFSET, 32'h0);
    chk(rd[5:4], 2'h3);
    finish_test();
  end
endmodule // hsc_halt_standby_tb

bind hsc_halt_standby hsc_halt_standby_properties #(.NUM_IRQ(NUM_IRQ)) hsc_halt_standby_properties_i (
  .clk(clk), .rst(rst), .haltExec(haltExec), .cpuFlags(cpuFlags), .vectorStart(vectorStart),
  .resumeStart(resumeStart), .resetVectorStart(resetVectorStart), .halted(halted),
  .irqRequest(irqRequest), .requestMaskFlag(requestMaskFlag), .rankSelectFlag(rankSelectFlag),
  .sysResetReq(sysResetReq), .wdtStoppableStrap(wdtStoppableStrap), .gates(gates),
  .cpuClkSource(cpuClkSource));

// file: hsc_pkg.sv
// Shared constants and types of the halt standby controller.
// Assumes one clock domain and an APB register port with 32-bit data.
package hsc_pkg;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // Control register fields.
  localparam int SRC_LSB      = 0;
  localparam int XMAIN_BIT    = 4;
  localparam int INTHI_BIT    = 5;
  localparam int SLOW_BIT     = 6;
  localparam int WATCH_BIT    = 7;
  localparam int BUZZ_BIT     = 8;
  localparam int PERIPH_BIT   = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0361;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_03f3;

  // Status register fields.
  localparam int STATE_LSB    = 0;
  localparam int HALTED_BIT   = 3;
  localparam int CAUSE_LSB    = 4;
  localparam int WDTOPT_BIT   = 6;

  // Release wait in CPU clocks, least figure of each documented pair.
  localparam int SERVICE_WAIT_CLKS = 8;
  localparam int RESUME_WAIT_CLKS  = 2;
  localparam int WAIT_W            = 4;
  localparam logic [WAIT_W-1:0] SERVICE_WAIT_CYC = WAIT_W'(SERVICE_WAIT_CLKS);
  localparam logic [WAIT_W-1:0] RESUME_WAIT_CYC  = WAIT_W'(RESUME_WAIT_CLKS);

  // CPU clock source selection.
  typedef enum logic [1:0] {
    SRC_HIGH_SPEED = 2'h0,
    SRC_INT_HIGH   = 2'h1,
    SRC_SUBSYSTEM  = 2'h2
  } hsc_src_type;

  // Last release cause.
  typedef enum logic [1:0] {
    CAUSE_NONE   = 2'h0,
    CAUSE_VECTOR = 2'h1,
    CAUSE_NEXT   = 2'h2,
    CAUSE_RESET  = 2'h3
  } hsc_cause_type;

  // Controller states, Gray coded along run, halt, wake.
  typedef enum logic [2:0] {
    ST_RUN       = 3'h0,
    ST_HALTED    = 3'h1,
    ST_WAKE_VEC  = 3'h3,
    ST_WAKE_NEXT = 3'h2,
    ST_RESET     = 3'h6
  } hsc_state_type;

  // Clock gate and enable outputs.
  typedef struct packed {
    logic cpu;
    logic flash;
    logic crystalMain;
    logic intHigh;
    logic slowInt;
    logic watchCrystal;
    logic wdt;
    logic buzzer;
    logic periph;
    logic extMainPass;
    logic extSubPass;
  } hsc_gate_type;

  // Global flags from the CPU core.
  typedef struct packed {
    logic globalIrqAllowFlag;
    logic inServiceLevelFlag;
  } hsc_cpu_flags_type;

endpackage

// file: hsc_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous level input; output changes once stages two and three agree.
`timescale 1ns/100ps
module hsc_sync3 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic out_reg;
  logic out_next;

  always_comb begin
    out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      s1_reg  <= asyncIn;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign syncOut = out_reg;
endmodule // hsc_sync3

// file: hsc_wait_timer.sv
// Down-counter for the release wait.
// Assumes load is a one-cycle pulse; done pulses the cycle the count expires.
`timescale 1ns/100ps
module hsc_wait_timer #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  output logic              done
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = loadVal;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == W'(1)) && !load;
endmodule // hsc_wait_timer
